/* File: eic_pkg.sv */
// Package: shared constants and types for the excitation input command logic
package eic_pkg;

  // Control source selection: local discrete, local panel or remote
  typedef enum logic [1:0] {
    EIC_SRC_DISCRETE = 2'h0,  // discrete_input_control
    EIC_SRC_PANEL    = 2'h1,  // panel_control
    EIC_SRC_REMOTE   = 2'h3
  } eic_src_t;

  // Regulation modes, Gray coded along the usual path
  typedef enum logic [1:0] {
    EIC_MODE_VOLT  = 2'h0,  // terminal_voltage_regulation_mode
    EIC_MODE_FIELD = 2'h1,  // field_current_regulation_mode
    EIC_MODE_REACT = 2'h3,  // reactive_power_regulation_mode
    EIC_MODE_PF    = 2'h2   // power_factor_regulation_mode
  } eic_mode_t;

  // Unload sequence states
  typedef enum logic [1:0] {
    EIC_UNL_IDLE = 2'h0,
    EIC_UNL_RUN  = 2'h1,
    EIC_UNL_TOUT = 2'h3
  } eic_unl_t;

  // Reset value, timer width and synchroniser depth
  localparam eic_mode_t EIC_MODE_RST = EIC_MODE_VOLT;
  localparam int        EIC_TMR_W    = 32;
  localparam int        EIC_SYNC_N   = 2;

endpackage : eic_pkg

/* File: eic_input_logic.sv */
// Design: excitation input decoding, mode selection and field breaker interlocks
module eic_input_logic #(
  parameter int TMR_W = eic_pkg::EIC_TMR_W
) (
  input  wire logic             clk,
  input  wire logic             srst,
  // Configuration
  input  wire logic [1:0]       cfg_ctrl_src,
  input  wire logic [TMR_W-1:0] cfg_fb_open_cycles,
  input  wire logic [TMR_W-1:0] cfg_unload_cycles,
  input  wire logic             cfg_int_trip_en,
  input  wire logic             cfg_vmatch_en,
  // Discrete field inputs
  input  wire logic             di_field_ovc,
  input  wire logic             di_speed_ok,
  input  wire logic             di_gen_brk_closed,
  input  wire logic             di_line_brk_closed,
  input  wire logic             di_vt_fault,
  input  wire logic             di_braking,
  input  wire logic             di_islanding,
  input  wire logic             di_common_trip,
  input  wire logic             di_vmatch,
  input  wire logic             di_backup_supply,
  input  wire logic             di_blk_uel,
  input  wire logic             di_blk_delayed_field_current_limiter,
  input  wire logic             di_blk_instant_field_current_limiter,
  input  wire logic             di_blk_scl,
  input  wire logic             di_motor_start,
  input  wire logic             di_blk_panel,
  // Process panel commands
  input  wire logic             pp_test_on,
  input  wire logic             pp_mode_volt,
  input  wire logic             pp_mode_field,
  input  wire logic             pp_mode_react,
  input  wire logic             pp_mode_pf,
  input  wire logic             pp_increase,
  input  wire logic             pp_decrease,
  input  wire logic             pp_fb_off,
  input  wire logic             pp_fb_on,
  input  wire logic             pp_unload,
  // Reactive power measured as near zero, from the regulator
  input  wire logic             q_at_zero,
  // Outputs
  output logic [1:0]            reg_mode,
  output logic                  fb_open_cmd,
  output logic                  fb_close_cmd,
  output logic                  ref_raise,
  output logic                  ref_lower,
  output logic                  test_mode,
  output logic                  speed_ok,
  output logic                  gen_brk_closed,
  output logic                  line_brk_closed,
  output logic                  braking_active,
  output logic                  vmatch_active,
  output logic                  backup_sel,
  output logic                  inh_uel,
  output logic                  inh_delayed_field_current_limiter,
  output logic                  inh_instant_field_current_limiter,
  output logic                  inh_scl,
  output logic                  fast_ramp,
  output logic                  panel_blocked,
  output logic                  q_unload_active,
  output logic                  q_unload_timeout
);

  localparam int NIN = 26;

  // ==========================================================================
  // Input synchronisers
  // Two stages for every discrete and panel pin; only the second stage is read by logic
  logic [NIN-1:0] raw, s1_q, s1_d, s2_q, s2_d, prev_q, prev_d, rise;

  assign raw = {di_field_ovc, di_speed_ok, di_gen_brk_closed, di_line_brk_closed,
                di_vt_fault, di_braking, di_islanding, di_common_trip, di_vmatch,
                di_backup_supply, di_blk_uel, di_blk_delayed_field_current_limiter, di_blk_instant_field_current_limiter, di_blk_scl,
                di_motor_start, di_blk_panel, pp_test_on, pp_mode_volt, pp_mode_field,
                pp_mode_react, pp_mode_pf, pp_increase, pp_decrease, pp_fb_off,
                pp_fb_on, pp_unload};

  // Bit positions in the synchronised vector
  localparam int B_OVC = 25, B_SPD = 24, B_GEN = 23, B_LINE = 22, B_VT = 21;
  localparam int B_BRK = 20, B_ISL = 19, B_TRIP = 18, B_VM = 17, B_BKP = 16;
  localparam int B_UEL = 15, B_DFC = 14, B_IFC = 13, B_SCL = 12, B_MOT = 11;
  localparam int B_BLK = 10, B_TST = 9, B_MV = 8, B_MF = 7, B_MQ = 6, B_MP = 5;
  localparam int B_INC = 4, B_DEC = 3, B_OFF = 2, B_ON = 1, B_UNL = 0;

  // Synchroniser and edge history next values
  always_comb begin
    s1_d   = raw;
    s2_d   = s1_q;
    prev_d = s2_q;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q   <= '0;
      s2_q   <= '0;
      prev_q <= '0;
    end else begin
      s1_q   <= s1_d;
      s2_q   <= s2_d;
      prev_q <= prev_d;
    end
  end

  assign rise = s2_q & ~prev_q;

  // ==========================================================================
  // Command gating
  logic src_di, src_pp, pp_ok;
  assign src_di = (cfg_ctrl_src == eic_pkg::EIC_SRC_DISCRETE);
  assign src_pp = (cfg_ctrl_src == eic_pkg::EIC_SRC_PANEL);
  // Panel block wins over panel source so a motor start cannot be disturbed
  assign pp_ok  = src_pp & ~s2_q[B_BLK];

  // ==========================================================================
  // Regulation mode and test mode
  logic [1:0] mode_q, mode_d;
  logic       test_q, test_d;

  // Safety forcing last so it overrides operator choice
  always_comb begin
    mode_d = mode_q;
    test_d = test_q;
    if (pp_ok && rise[B_TST]) begin
      test_d = 1'b1;
    end
    if (pp_ok) begin
      // Fixed priority: field, voltage, reactive, power factor
      if (rise[B_MF]) begin
        mode_d = eic_pkg::EIC_MODE_FIELD;
      end else if (rise[B_MV]) begin
        mode_d = eic_pkg::EIC_MODE_VOLT;
      end else if (rise[B_MQ]) begin
        mode_d = eic_pkg::EIC_MODE_REACT;
      end else if (rise[B_MP]) begin
        mode_d = eic_pkg::EIC_MODE_PF;
      end
    end
    if (rise[B_ISL] && (mode_d == eic_pkg::EIC_MODE_REACT ||
                        mode_d == eic_pkg::EIC_MODE_PF)) begin
      mode_d = eic_pkg::EIC_MODE_VOLT;
    end
    if (s2_q[B_VT]) begin
      mode_d = eic_pkg::EIC_MODE_FIELD;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q <= eic_pkg::EIC_MODE_RST;
      test_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      test_q <= test_d;
    end
  end

  // ==========================================================================
  // Field breaker: overcurrent delay timer, trips and panel commands
  // Counter step sized to the timer so no addition pads a one-bit constant
  localparam logic [TMR_W-1:0] CNT_STEP = TMR_W'(1);
  logic [TMR_W-1:0] ovc_cnt_q, ovc_cnt_d;
  logic             ovc_run_q, ovc_run_d;
  logic             fbo_q, fbo_d, fbc_q, fbc_d;

  // Open always wins over close; one-cycle pulses
  always_comb begin
    ovc_cnt_d = ovc_cnt_q;
    ovc_run_d = ovc_run_q;
    fbo_d     = 1'b0;
    fbc_d     = 1'b0;
    if (src_di && rise[B_OVC]) begin
      ovc_run_d = 1'b1;
      ovc_cnt_d = '0;
    end else if (ovc_run_q) begin
      if (!src_di) begin
        ovc_run_d = 1'b0;
      end else if (ovc_cnt_q >= cfg_fb_open_cycles) begin
        ovc_run_d = 1'b0;
        fbo_d     = 1'b1;
      end else begin
        ovc_cnt_d = ovc_cnt_q + CNT_STEP;
      end
    end
    if (cfg_int_trip_en && rise[B_TRIP]) begin
      fbo_d = 1'b1;
    end
    if (pp_ok && rise[B_OFF]) begin
      fbo_d = 1'b1;
    end
    if (pp_ok && rise[B_ON] && !fbo_d) begin
      fbc_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ovc_cnt_q <= '0;
      ovc_run_q <= 1'b0;
      fbo_q     <= 1'b0;
      fbc_q     <= 1'b0;
    end else begin
      ovc_cnt_q <= ovc_cnt_d;
      ovc_run_q <= ovc_run_d;
      fbo_q     <= fbo_d;
      fbc_q     <= fbc_d;
    end
  end

  // ==========================================================================
  // Reactive power unload sequence
  eic_pkg::eic_unl_t unl_q, unl_d;
  logic [TMR_W-1:0]  unl_cnt_q, unl_cnt_d;

  // Timeout is reported and the sequence stops; reference stays unloaded no longer
  always_comb begin
    unl_d     = unl_q;
    unl_cnt_d = unl_cnt_q;
    case (unl_q)
      eic_pkg::EIC_UNL_IDLE: begin
        if (pp_ok && rise[B_UNL]) begin
          unl_d     = eic_pkg::EIC_UNL_RUN;
          unl_cnt_d = '0;
        end
      end
      eic_pkg::EIC_UNL_RUN: begin
        if (q_at_zero) begin
          unl_d = eic_pkg::EIC_UNL_IDLE;
        end else if (unl_cnt_q >= cfg_unload_cycles) begin
          unl_d = eic_pkg::EIC_UNL_TOUT;
        end else begin
          unl_cnt_d = unl_cnt_q + CNT_STEP;
        end
      end
      eic_pkg::EIC_UNL_TOUT: begin
        if (pp_ok && rise[B_UNL]) begin
          unl_d     = eic_pkg::EIC_UNL_RUN;
          unl_cnt_d = '0;
        end
      end
      default: unl_d = eic_pkg::EIC_UNL_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      unl_q     <= eic_pkg::EIC_UNL_IDLE;
      unl_cnt_q <= '0;
    end else begin
      unl_q     <= unl_d;
      unl_cnt_q <= unl_cnt_d;
    end
  end

  // ==========================================================================
  // Registered outputs
  logic [15:0] out_d, out_q;

  // Levels follow synchronised inputs or the unload state; raise/lower are edge pulses
  always_comb begin
    out_d = {
      pp_ok & rise[B_INC] & ~rise[B_DEC],
      pp_ok & rise[B_DEC] & ~rise[B_INC],
      s2_q[B_SPD],
      s2_q[B_GEN],
      s2_q[B_LINE],
      s2_q[B_BRK],
      s2_q[B_VM] & cfg_vmatch_en,
      s2_q[B_BKP],
      s2_q[B_UEL],
      s2_q[B_DFC],
      s2_q[B_IFC],
      s2_q[B_SCL],
      s2_q[B_MOT],
      s2_q[B_BLK],
      unl_d == eic_pkg::EIC_UNL_RUN,
      unl_d == eic_pkg::EIC_UNL_TOUT
    };
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign reg_mode     = mode_q;
  assign test_mode    = test_q;
  assign fb_open_cmd  = fbo_q;
  assign fb_close_cmd = fbc_q;
  assign {ref_raise, ref_lower, speed_ok, gen_brk_closed, line_brk_closed,
          braking_active, vmatch_active, backup_sel, inh_uel, inh_delayed_field_current_limiter, inh_instant_field_current_limiter,
          inh_scl, fast_ramp, panel_blocked, q_unload_active,
          q_unload_timeout} = out_q;

endmodule : eic_input_logic

/* File: eic_chk.sv */
// Checker: port-level properties of the excitation input logic
module eic_chk (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [1:0] cfg_ctrl_src,
  input wire logic       cfg_int_trip_en,
  input wire logic       di_speed_ok,
  input wire logic       di_vt_fault,
  input wire logic       di_common_trip,
  input wire logic       di_blk_uel,
  input wire logic       di_blk_delayed_field_current_limiter,
  input wire logic       di_blk_instant_field_current_limiter,
  input wire logic       di_blk_scl,
  input wire logic       di_blk_panel,
  input wire logic       pp_increase,
  input wire logic       pp_decrease,
  input wire logic       pp_fb_on,
  input wire logic [1:0] reg_mode,
  input wire logic       fb_open_cmd,
  input wire logic       fb_close_cmd,
  input wire logic       ref_raise,
  input wire logic       test_mode,
  input wire logic       speed_ok,
  input wire logic       inh_uel,
  input wire logic       inh_delayed_field_current_limiter,
  input wire logic       inh_instant_field_current_limiter,
  input wire logic       inh_scl
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Settle count, so three-deep samples never reach back into reset
  logic [1:0] up_q;
  logic [1:0] up_d;
  always_comb up_d = srst ? 2'h0 : up_q + {1'b0, up_q != 2'h3};
  always_ff @(posedge clk) up_q <= up_d;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ====================
  // Properties
  property p_mirror;
    up_q == 2'h3 |-> {speed_ok, inh_uel, inh_delayed_field_current_limiter, inh_instant_field_current_limiter, inh_scl} == {$past(di_speed_ok, 3),
      $past(di_blk_uel, 3), $past(di_blk_delayed_field_current_limiter, 3), $past(di_blk_instant_field_current_limiter, 3), $past(di_blk_scl, 3)};
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror wrong");
  property p_vt;
    up_q == 2'h3 && $past(di_vt_fault, 3) |-> reg_mode == eic_pkg::EIC_MODE_FIELD;
  endproperty
  a_vt: assert property (p_vt) else $error("mode not field on fault");
  property p_trip;
    up_q == 2'h3 && $rose(di_common_trip) && cfg_int_trip_en |-> ##3 fb_open_cmd;
  endproperty
  a_trip: assert property (p_trip) else $error("trip did not open");
  property p_close;
    $rose(pp_fb_on) && cfg_ctrl_src == 2'h1 && !di_blk_panel |-> ##3 (fb_close_cmd || fb_open_cmd);
  endproperty
  a_close: assert property (p_close) else $error("close missing");
  property p_src;
    up_q == 2'h3 && fb_close_cmd |-> $past(cfg_ctrl_src, 1) == 2'h1 && !$past(di_blk_panel, 3);
  endproperty
  a_src: assert property (p_src) else $error("close while refused");
  property p_raise;
    $rose(pp_increase) && !pp_decrease && cfg_ctrl_src == 2'h1 && !di_blk_panel |-> ##3 ref_raise;
  endproperty
  a_raise: assert property (p_raise) else $error("raise missing");
  property p_pulse;
    ref_raise |=> !ref_raise;
  endproperty
  a_pulse: assert property (p_pulse) else $error("raise held");
  property p_test;
    test_mode |=> test_mode;
  endproperty
  a_test: assert property (p_test) else $error("test mode dropped");
endmodule : eic_chk
bind eic_input_logic eic_chk eic_chk_i (
  .clk             (clk),
  .srst            (srst),
  .cfg_ctrl_src    (cfg_ctrl_src),
  .cfg_int_trip_en (cfg_int_trip_en),
  .di_speed_ok     (di_speed_ok),
  .di_vt_fault     (di_vt_fault),
  .di_common_trip  (di_common_trip),
  .di_blk_uel      (di_blk_uel),
  .di_blk_delayed_field_current_limiter     (di_blk_delayed_field_current_limiter),
  .di_blk_instant_field_current_limiter     (di_blk_instant_field_current_limiter),
  .di_blk_scl      (di_blk_scl),
  .di_blk_panel    (di_blk_panel),
  .pp_increase     (pp_increase),
  .pp_decrease     (pp_decrease),
  .pp_fb_on        (pp_fb_on),
  .reg_mode        (reg_mode),
  .fb_open_cmd     (fb_open_cmd),
  .fb_close_cmd    (fb_close_cmd),
  .ref_raise       (ref_raise),
  .test_mode       (test_mode),
  .speed_ok        (speed_ok),
  .inh_uel         (inh_uel),
  .inh_delayed_field_current_limiter        (inh_delayed_field_current_limiter),
  .inh_instant_field_current_limiter        (inh_instant_field_current_limiter),
  .inh_scl         (inh_scl)
);

/* File: eic_plant.sv */
// Partner: field breaker and reactive power response of the plant
module eic_plant (
  input  wire logic       clk,
  input  wire logic       fb_open_cmd,
  input  wire logic       fb_close_cmd,
  input  wire logic       q_unload_active,
  input  wire logic [7:0] q_delay,
  output logic            fb_closed,
  output logic            q_at_zero
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q = 8'h0;
  initial fb_closed = 1'b0;
  initial q_at_zero = 1'b0;
  // Open wins over close, a trip must never be overridden; a large delay makes a slow plant
  always @(posedge clk) begin
    if (fb_open_cmd) fb_closed <= 1'b0;
    else if (fb_close_cmd) fb_closed <= 1'b1;
    cnt_q <= q_unload_active ? cnt_q + 8'h1 : 8'h0;
    q_at_zero <= q_unload_active && cnt_q >= q_delay;
  end
endmodule : eic_plant

/* File: eic_tb.sv */
// Testbench: directed scenarios for the excitation input logic
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, srst = 1'b1, trip_en = 1'b0, vm_en = 1'b0;
  logic [1:0] src = 2'h1;
  logic [31:0] t_open = 32'h14, t_unl = 32'h1e;
  logic [15:0] di = 16'h0;
  logic [9:0] pp = 10'h0;
  logic [7:0] q_delay = 8'h5;
  wire [1:0] mode;
  wire [10:0] lv;
  wire fb_open, fb_close, raise, lower, test, vm_act, q_act, q_tout, q_zero, fb_closed;
  int n_mismatch = 0, checks = 0, n_op, n_cl, n_up, n_dn;
  always #2 clk = ~clk;
  eic_input_logic eic_input_logic_i (.clk(clk), .srst(srst), .cfg_ctrl_src(src),
    .cfg_fb_open_cycles(t_open), .cfg_unload_cycles(t_unl), .cfg_int_trip_en(trip_en),
    .cfg_vmatch_en(vm_en), .di_field_ovc(di[0]), .di_speed_ok(di[1]), .di_gen_brk_closed(di[2]),
    .di_line_brk_closed(di[3]), .di_vt_fault(di[4]), .di_braking(di[5]), .di_islanding(di[6]),
    .di_common_trip(di[7]), .di_vmatch(di[8]), .di_backup_supply(di[9]), .di_blk_uel(di[10]),
    .di_blk_delayed_field_current_limiter(di[11]), .di_blk_instant_field_current_limiter(di[12]), .di_blk_scl(di[13]), .di_motor_start(di[14]),
    .di_blk_panel(di[15]), .pp_test_on(pp[0]), .pp_mode_volt(pp[1]), .pp_mode_field(pp[2]),
    .pp_mode_react(pp[3]), .pp_mode_pf(pp[4]), .pp_increase(pp[5]), .pp_decrease(pp[6]),
    .pp_fb_off(pp[7]), .pp_fb_on(pp[8]), .pp_unload(pp[9]), .q_at_zero(q_zero),
    .reg_mode(mode), .fb_open_cmd(fb_open), .fb_close_cmd(fb_close), .ref_raise(raise),
    .ref_lower(lower), .test_mode(test), .speed_ok(lv[0]), .gen_brk_closed(lv[1]),
    .line_brk_closed(lv[2]), .braking_active(lv[3]), .vmatch_active(vm_act),
    .backup_sel(lv[4]), .inh_uel(lv[5]), .inh_delayed_field_current_limiter(lv[6]), .inh_instant_field_current_limiter(lv[7]), .inh_scl(lv[8]),
    .fast_ramp(lv[9]), .panel_blocked(lv[10]), .q_unload_active(q_act),
    .q_unload_timeout(q_tout));
  eic_plant eic_plant_i (.clk(clk), .fb_open_cmd(fb_open), .fb_close_cmd(fb_close),
    .q_unload_active(q_act), .q_delay(q_delay), .fb_closed(fb_closed), .q_at_zero(q_zero));
  // ====================
  // Shared tasks; stimulus moves only at falling edges, pulses are counted there
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask : chk
  task run(input int n);
    repeat (n) begin
      @(negedge clk);
      n_op += (fb_open === 1'b1);
      n_cl += (fb_close === 1'b1);
      n_up += (raise === 1'b1);
      n_dn += (lower === 1'b1);
    end
  endtask : run
  // Hold a command six cycles, then keep it low long enough to re-arm the edge detector
  task cmd(input logic [9:0] pm, input logic [15:0] dm);
    {n_op, n_cl, n_up, n_dn} = 128'h0;
    pp |= pm;
    di |= dm;
    run(6);
    pp &= ~pm;
    di &= ~dm;
    run(5);
  endtask : cmd
  task summarize;
    if (n_mismatch == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  // ====================
  // Scenarios
  task t_mirror;
    for (int i = 0; i < 17; i++) begin
      di = (i < 16) ? 16'hfe2e & (16'h1 << i) : 16'hfe2e;
      run(4);
      chk(lv, {di[15:9], di[5], di[3:1]});
    end
    for (int i = 0; i < 4; i++) begin
      {vm_en, di} = {i[1], 7'h0, i[0], 8'h0};
      run(4);
      chk(vm_act, i[0] & i[1]);
    end
  endtask : t_mirror
  task t_modes;
    eic_pkg::eic_mode_t m [1:4];
    m = '{eic_pkg::EIC_MODE_VOLT, eic_pkg::EIC_MODE_FIELD, eic_pkg::EIC_MODE_REACT,
      eic_pkg::EIC_MODE_PF};
    for (int i = 4; i > 0; i--) begin
      cmd(10'h1 << i, 16'h0);
      chk(mode, m[i]);
    end
    cmd(10'h018, 16'h0);
    chk(mode, eic_pkg::EIC_MODE_REACT);
    cmd(10'h00e, 16'h0);
    chk(mode, eic_pkg::EIC_MODE_FIELD);
    cmd(10'h008, 16'h0);
    cmd(10'h0, 16'h40);
    chk(mode, eic_pkg::EIC_MODE_VOLT);
    di[4] = 1'b1;
    cmd(10'h008, 16'h0);
    chk(mode, eic_pkg::EIC_MODE_FIELD);
    di[4] = 1'b0;
    run(4);
  endtask : t_modes
  task t_panel;
    for (int i = 0; i < 3; i++) begin
      src = {i[0], i != 0};
      di[15] = (i == 2);
      run(4);
      cmd(10'h120, 16'h0);
      chk(n_cl + n_up, 0);
    end
    {src, di[15]} = 3'h2;
    run(4);
    cmd(10'h100, 16'h0);
    chk(n_cl, 1);
    chk(fb_closed, 1);
    cmd(10'h020, 16'h0);
    chk({n_up[3:0], n_dn[3:0]}, 8'h10);
    cmd(10'h040, 16'h0);
    chk({n_up[3:0], n_dn[3:0]}, 8'h01);
    cmd(10'h080, 16'h0);
    chk({n_op[3:0], 3'h0, fb_closed}, 8'h10);
  endtask : t_panel
  task t_trip;
    int n;
    for (int i = 0; i < 2; i++) begin
      trip_en = i[0];
      cmd(10'h0, 16'h80);
      chk(n_op, i);
    end
    cmd(10'h0, 16'h0);
    di[0] = 1'b1;
    run(40);
    chk(n_op, 0);
    di[0] = 1'b0;
    run(5);
    {src, di[0], n} = {3'h1, 32'h0};
    while (fb_open !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk(n >= 20 && n <= 28, 1);
    {src, di[0]} = 3'h2;
    run(5);
  endtask : t_trip
  task t_rest;
    chk(test, 0);
    cmd(10'h001, 16'h0);
    run(10);
    chk(test, 1);
    for (int i = 0; i < 2; i++) begin
      q_delay = i ? 8'hc8 : 8'h5;
      pp[9] = 1'b1;
      run(4);
      chk(q_act, 1);
      run(40);
      chk({q_act, q_tout}, {1'b0, i[0]});
      pp[9] = 1'b0;
      run(5);
    end
    // Mid-run reset: sticky test mode, mode and timeout flag must all clear
    srst = 1'b1;
    run(4);
    srst = 1'b0;
    run(2);
    chk({test, mode, q_tout}, {1'b0, eic_pkg::EIC_MODE_RST, 1'b0});
  endtask : t_rest
  // ====================
  // Main sequence and watchdog; the watchdog span is nearly nineteen times the expected run
  initial begin
    run(20);
    srst = 1'b0;
    run(2);
    t_mirror;
    t_modes;
    t_panel;
    t_trip;
    t_rest;
    summarize;
  end
  initial begin
    #40000;
    n_mismatch++;
    summarize;
  end
endmodule : tb
